// File: rtl/mba_gpr_ram.sv
// Static RAM holding the general purpose registers.
// Assumes one clock; read data is registered, one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module mba_gpr_ram
    import mba_pkg::*;
#(
    parameter int DEPTH = GPR_DEPTH,
    parameter int AW = FADDR_W,
    parameter int DW = DATA_W
) (
    // Clock
    input wire logic ref_clk_i,
    // Access
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_r;

    // No reset: RAM contents are undefined at power-up
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_r <= mem[addr_i];
    end

    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// File: rtl/mba_pkg.sv
// Package for the memory bank addressing block.
// Assumes a single 40 MHz core clock; shared by the top and its RAM.
package mba_pkg;
    localparam int PC_W = 13;
    localparam int PWORD_W = 14;
    localparam int FADDR_W = 9;
    localparam int DADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
    localparam logic [PC_W-1:0] INT_VEC = 13'h0004;
    localparam int STATUS_RP0_POS = 5;
    localparam int STATUS_RP1_POS = 6;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
    localparam logic [DATA_W-1:0] PTR_RST = 8'h00;
    localparam logic [DADDR_W-1:0] SFR_LIMIT = 7'h20;
    localparam logic [DADDR_W-1:0] IND_ADDR = 7'h00;
    localparam logic [DADDR_W-1:0] STATUS_ADDR = 7'h03;
    localparam logic [DADDR_W-1:0] PTR_ADDR = 7'h04;
    localparam logic [DADDR_W-1:0] COMMON_BASE = 7'h70;
    localparam int GPR_DEPTH = 512;

    typedef enum logic [1:0] {
        MBA_BANK0,
        MBA_BANK1,
        MBA_BANK2,
        MBA_BANK3
    } mba_bank_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic indirect;
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mba_dreq_t;

    typedef struct packed {
        logic valid;
        logic is_sfr;
        logic [FADDR_W-1:0] faddr;
        logic [DATA_W-1:0] rdata;
    } mba_dresp_t;

    typedef struct packed {
        logic valid;
        logic [PC_W-1:0] addr;
        logic [PWORD_W-1:0] word;
    } mba_fetch_t;
endpackage

// File: rtl/mba_top.sv
// Program and data memory address organisation for an 8-bit core.
// Assumes the core supplies fetch, interrupt and data requests on ref_clk_i.
//
// Operation
// - Thirteen-bit program counter addresses up to 8K words of 14 bits.
// - Large variant implements 8K words, small variant 4K words.
// - Fetch beyond implemented size wraps onto implemented locations.
// - Fetch starts at address 0000h after reset.
// - Taking an interrupt redirects fetch to address 0004h.
// - Status bits 6 and 5 select bank 0 to 3.
// - Each bank spans 128 directly addressable bytes up to 7Fh.
// - Low bank addresses decode to SFRs, higher ones to RAM.
// - Every implemented bank holds SFRs in its low region.
// - Frequently used SFRs are reachable from several banks.
// - Fetch and data access use separate buses concurrently.
// - User code can read program memory as data.
// - Registers reachable directly or via the indirect pointer register.
`timescale 1ns/10ps
`default_nettype none
module mba_top
    import mba_pkg::*;
#(
    parameter int PROG_WORDS = 8192
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Instruction fetch side
    input wire logic fetch_adv_i,
    input wire logic jump_i,
    input wire logic [PC_W-1:0] jump_addr_i,
    input wire logic int_take_i,
    output logic [PC_W-1:0] pc_o,
    output mba_fetch_t fetch_o,
    // Program store
    output logic [PC_W-1:0] pmem_addr_o,
    input wire logic [PWORD_W-1:0] pmem_word_i,
    // Program memory read as data
    input wire logic pread_req_i,
    input wire logic [PC_W-1:0] pread_addr_i,
    output logic [PC_W-1:0] pread_addr_o,
    output logic pread_valid_o,
    output logic [PWORD_W-1:0] pread_word_o,
    // Data access side
    input wire mba_dreq_t dreq_i,
    output mba_dresp_t dresp_o,
    output logic [DATA_W-1:0] status_o,
    output logic [DATA_W-1:0] ptr_o,
    // External SFR bus
    output logic sfr_we_o,
    output logic [FADDR_W-1:0] sfr_addr_o,
    output logic [DATA_W-1:0] sfr_wdata_o,
    input wire logic [DATA_W-1:0] sfr_rdata_i
);
    localparam int IMPL_W = $clog2(PROG_WORDS);

    // Program counter
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic fvalid_r;
    logic fvalid_nxt;
    logic [PC_W-1:0] faddr_r;
    logic [PC_W-1:0] faddr_nxt;
    logic fetch_take;
    logic pc_move;

    // Wrap to implemented size; high PC bits are kept but ignored
    function automatic logic [PC_W-1:0] wrap(input logic [PC_W-1:0] a);
        logic [PC_W-1:0] m;
        m = PC_W'((1 << IMPL_W) - 1);
        return a & m;
    endfunction

    always_comb begin
        fetch_take = fetch_adv_i && !jump_i && !int_take_i;
        pc_move = fetch_adv_i || jump_i || int_take_i;
        pc_nxt = pc_r;
        fvalid_nxt = 1'b0;
        faddr_nxt = faddr_r;
        if (int_take_i) begin
            pc_nxt = INT_VEC;
        end else if (jump_i) begin
            pc_nxt = jump_addr_i;
        end else if (fetch_adv_i) begin
            pc_nxt = pc_r + 13'h0001;
            fvalid_nxt = 1'b1;
            faddr_nxt = pc_r;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_r <= RESET_VEC;
            fvalid_r <= 1'b0;
            faddr_r <= RESET_VEC;
        end else begin
            pc_r <= pc_nxt;
            fvalid_r <= fvalid_nxt;
            faddr_r <= faddr_nxt;
        end
    end

    // Program store address register; separate from the data path
    logic [PC_W-1:0] paddr_r;
    logic [PC_W-1:0] paddr_nxt;
    logic pread_pend_r;
    logic pread_pend_nxt;
    logic pread_valid_r;
    logic pread_valid_nxt;
    logic [PWORD_W-1:0] pread_word_r;
    logic [PWORD_W-1:0] pread_word_nxt;
    logic [PC_W-1:0] pread_addr_r;
    logic [PC_W-1:0] pread_addr_nxt;
    logic [PWORD_W-1:0] fword_r;
    logic [PWORD_W-1:0] fword_nxt;
    logic [PWORD_W-1:0] cur_word;
    logic [PWORD_W-1:0] fout_r;
    logic [PWORD_W-1:0] fout_nxt;

    // Program read borrows the store port only while the PC stands still,
    // so the held word below always belongs to pc_r
    always_comb begin
        paddr_nxt = wrap(pc_nxt);
        pread_pend_nxt = 1'b0;
        pread_addr_nxt = pread_addr_r;
        if (pread_req_i && !pc_move) begin
            paddr_nxt = wrap(pread_addr_i);
            pread_pend_nxt = 1'b1;
            pread_addr_nxt = wrap(pread_addr_i);
        end
        pread_valid_nxt = pread_pend_r;
        pread_word_nxt = pread_pend_r ? pmem_word_i : pread_word_r;
        cur_word = pread_pend_r ? fword_r : pmem_word_i;
        fword_nxt = cur_word;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            paddr_r <= RESET_VEC;
            pread_pend_r <= 1'b0;
            pread_valid_r <= 1'b0;
            pread_word_r <= '0;
            pread_addr_r <= '0;
            fword_r <= '0;
        end else begin
            paddr_r <= paddr_nxt;
            pread_pend_r <= pread_pend_nxt;
            pread_valid_r <= pread_valid_nxt;
            pread_word_r <= pread_word_nxt;
            pread_addr_r <= pread_addr_nxt;
            fword_r <= fword_nxt;
        end
    end

    // Fetch word captured when the fetch is taken; output stays a flop
    always_comb begin
        fout_nxt = fout_r;
        if (fetch_take) begin
            fout_nxt = cur_word;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fout_r <= '0;
        end else begin
            fout_r <= fout_nxt;
        end
    end

    // Data side: status and pointer registers are mirrored in every bank
    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] status_nxt;
    logic [DATA_W-1:0] ptr_r;
    logic [DATA_W-1:0] ptr_nxt;
    mba_bank_t bank;
    logic [FADDR_W-1:0] faddr;
    logic [DADDR_W-1:0] off;
    logic is_sfr;
    logic is_status;
    logic is_ptr;
    logic is_ind;
    logic ram_we;
    logic [FADDR_W-1:0] ram_addr;
    logic [DATA_W-1:0] ram_rdata;

    always_comb begin
        bank = mba_bank_t'({status_r[STATUS_RP1_POS], status_r[STATUS_RP0_POS]});
        is_ind = dreq_i.indirect || (dreq_i.addr == IND_ADDR);
        if (is_ind) begin
            // Pointer supplies low 8 bits; IRP bit not modelled, bank bit 1 used
            faddr = {status_r[STATUS_RP1_POS], ptr_r};
        end else begin
            faddr = {bank, dreq_i.addr};
        end
        off = faddr[DADDR_W-1:0];
        is_sfr = (off < SFR_LIMIT);
        // Shared top block maps to bank 0 copy
        ram_addr = (off >= COMMON_BASE) ? {2'b00, off} : faddr;
        is_status = (off == STATUS_ADDR);
        is_ptr = (off == PTR_ADDR);
        ram_we = dreq_i.valid && dreq_i.write && !is_sfr;
    end

    always_comb begin
        status_nxt = status_r;
        ptr_nxt = ptr_r;
        if (dreq_i.valid && dreq_i.write && is_status) begin
            status_nxt = dreq_i.wdata;
        end
        if (dreq_i.valid && dreq_i.write && is_ptr) begin
            ptr_nxt = dreq_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_r <= STATUS_RST;
            ptr_r <= PTR_RST;
        end else begin
            status_r <= status_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    mba_gpr_ram #(
        .DEPTH(GPR_DEPTH),
        .AW(FADDR_W),
        .DW(DATA_W)
    ) u_ram (
        .ref_clk_i(ref_clk_i),
        .we_i(ram_we),
        .addr_i(ram_addr),
        .wdata_i(dreq_i.wdata),
        .rdata_o(ram_rdata)
    );

    // Response pipeline, one cycle behind the request
    logic rvalid_r;
    logic rvalid_nxt;
    logic rsfr_r;
    logic rsfr_nxt;
    logic [1:0] rsel_r;
    logic [1:0] rsel_nxt;
    logic [FADDR_W-1:0] rfaddr_r;
    logic [FADDR_W-1:0] rfaddr_nxt;
    logic sfr_we_r;
    logic sfr_we_nxt;
    logic [FADDR_W-1:0] sfr_addr_r;
    logic [FADDR_W-1:0] sfr_addr_nxt;
    logic [DATA_W-1:0] sfr_wdata_r;
    logic [DATA_W-1:0] sfr_wdata_nxt;
    logic [DATA_W-1:0] rdata;

    always_comb begin
        rvalid_nxt = dreq_i.valid && !dreq_i.write;
        rsfr_nxt = is_sfr;
        rsel_nxt = is_status ? 2'h1 : (is_ptr ? 2'h2 : 2'h0);
        rfaddr_nxt = dreq_i.valid ? faddr : rfaddr_r;
        // Separate from program bus, so data runs every cycle
        sfr_we_nxt = dreq_i.valid && dreq_i.write && is_sfr && !is_status && !is_ptr;
        sfr_addr_nxt = dreq_i.valid ? faddr : sfr_addr_r;
        sfr_wdata_nxt = dreq_i.wdata;
        case (rsel_r)
            2'h1: rdata = status_r;
            2'h2: rdata = ptr_r;
            default: rdata = rsfr_r ? sfr_rdata_i : ram_rdata;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rsfr_r <= 1'b0;
            rsel_r <= 2'h0;
            rfaddr_r <= '0;
            sfr_we_r <= 1'b0;
            sfr_addr_r <= '0;
            sfr_wdata_r <= '0;
        end else begin
            rvalid_r <= rvalid_nxt;
            rsfr_r <= rsfr_nxt;
            rsel_r <= rsel_nxt;
            rfaddr_r <= rfaddr_nxt;
            sfr_we_r <= sfr_we_nxt;
            sfr_addr_r <= sfr_addr_nxt;
            sfr_wdata_r <= sfr_wdata_nxt;
        end
    end

    // Read data muxed after the register: SFR reads depend on the outside
    assign pc_o = pc_r;
    assign pmem_addr_o = paddr_r;
    assign fetch_o = '{valid: fvalid_r, addr: faddr_r, word: fout_r};
    assign pread_addr_o = pread_addr_r;
    assign pread_valid_o = pread_valid_r;
    assign pread_word_o = pread_word_r;
    assign dresp_o = '{valid: rvalid_r, is_sfr: rsfr_r, faddr: rfaddr_r, rdata: rdata};
    assign status_o = status_r;
    assign ptr_o = ptr_r;
    assign sfr_we_o = sfr_we_r;
    assign sfr_addr_o = sfr_addr_r;
    assign sfr_wdata_o = sfr_wdata_r;
endmodule
`default_nettype wire

// File: tb/mba_top_assertions.sv
// Checker for mba_top, watching only its ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module mba_top_chk
    import mba_pkg::*;
#(
    parameter int PROG_WORDS = 8192
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Fetch side
    input wire logic fetch_adv_i,
    input wire logic jump_i,
    input wire logic int_take_i,
    input wire logic [PC_W-1:0] pc_o,
    input wire mba_fetch_t fetch_o,
    input wire logic [PC_W-1:0] pmem_addr_o,
    input wire logic pread_req_i,
    input wire logic pread_valid_o,
    // Data side
    input wire mba_dreq_t dreq_i,
    input wire mba_dresp_t dresp_o,
    input wire logic [DATA_W-1:0] status_o,
    input wire logic [DATA_W-1:0] ptr_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Plain advance only; interrupt and jump outrank it
    logic adv;
    logic rd;
    logic dir_rd;
    logic low;
    logic [FADDR_W-1:0] dir_fa;
    logic [FADDR_W-1:0] ind_fa;
    assign adv = fetch_adv_i && !jump_i && !int_take_i;
    assign rd = dreq_i.valid && !dreq_i.write;
    assign dir_rd = rd && !dreq_i.indirect && dreq_i.addr != IND_ADDR && dreq_i.addr < COMMON_BASE;
    assign low = dreq_i.addr < SFR_LIMIT;
    assign dir_fa = {status_o[STATUS_RP1_POS:STATUS_RP0_POS], dreq_i.addr};
    assign ind_fa = {status_o[STATUS_RP1_POS], ptr_o};
    sequence s_pread_req;
        pread_req_i && !fetch_adv_i && !jump_i && !int_take_i;
    endsequence
    sequence s_pread_ans;
        ##2 pread_valid_o;
    endsequence
    property p_rst; $fell(rst_i) |-> pc_o == RESET_VEC; endproperty
    property p_adv; adv |=> pc_o == $past(pc_o) + 13'h0001; endproperty
    property p_fetch; adv |=> fetch_o.valid && fetch_o.addr == $past(pc_o); endproperty
    property p_wrap; adv |=> int'(pmem_addr_o) == int'(pc_o) % PROG_WORDS; endproperty
    property p_int; int_take_i |=> pc_o == INT_VEC; endproperty
    property p_pread; s_pread_req |-> s_pread_ans; endproperty
    property p_bank; dir_rd |=> dresp_o.valid && dresp_o.faddr == $past(dir_fa); endproperty
    property p_sfr; dir_rd |=> dresp_o.is_sfr == $past(low); endproperty
    property p_ind; rd && dreq_i.indirect |=> dresp_o.faddr == $past(ind_fa); endproperty
    a_rst: assert property (p_rst) else $error("fetch not at reset vector");
    a_adv: assert property (p_adv) else $error("pc not advanced");
    a_fetch: assert property (p_fetch) else $error("fetch result wrong");
    a_wrap: assert property (p_wrap) else $error("store address not wrapped");
    a_int: assert property (p_int) else $error("interrupt vector missed");
    a_pread: assert property (p_pread) else $error("program read not answered");
    a_bank: assert property (p_bank) else $error("direct address wrong");
    a_sfr: assert property (p_sfr) else $error("sfr decode wrong");
    a_ind: assert property (p_ind) else $error("indirect address wrong");
endmodule
bind mba_top mba_top_chk #(.PROG_WORDS(PROG_WORDS)) i_mba_top_chk (.ref_clk_i, .rst_i,
    .fetch_adv_i, .jump_i, .int_take_i, .pc_o, .fetch_o, .pmem_addr_o, .pread_req_i,
    .pread_valid_o, .dreq_i, .dresp_o, .status_o, .ptr_o);
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for mba_top in its 4K-word variant.
// Assumes the package and design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import mba_pkg::*;
;
    localparam int PW = 4096;
    localparam logic [12:0] WM = 13'(PW - 1);
    logic ref_clk_i = 1'b0, rst_i = 1'b1, fetch_adv_i = 1'b0, jump_i = 1'b0;
    logic int_take_i = 1'b0, pread_req_i = 1'b0, pread_valid_o, sfr_we_o, sw;
    logic [12:0] jump_addr_i = 13'h0000, pread_addr_i = 13'h0000, pc_o, pmem_addr_o, a;
    logic [12:0] pread_addr_o;
    logic [13:0] pmem_word_i, pread_word_o;
    logic [7:0] status_o, ptr_o, sfr_wdata_o, sfr_rdata_i, d, cv;
    logic [8:0] sfr_addr_o, sa;
    logic [6:0] ad, sf;
    mba_dreq_t dreq_i = '0;
    mba_dresp_t dresp_o, rsp;
    mba_fetch_t fetch_o;
    int error_cnt = 0, comparisons = 0, cycles = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    // Store contents depend on address, so a wrong wrap shows up
    function automatic logic [13:0] pw(input logic [12:0] x);
        return {x[0], x} ^ 14'h2a5a;
    endfunction
    assign pmem_word_i = pw(pmem_addr_o);
    assign sfr_rdata_i = sfr_addr_o[7:0] ^ 8'h3c;
    mba_top #(.PROG_WORDS(PW)) i_mba_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .fetch_adv_i(fetch_adv_i), .jump_i(jump_i), .jump_addr_i(jump_addr_i),
        .int_take_i(int_take_i), .pc_o(pc_o), .fetch_o(fetch_o), .pmem_addr_o(pmem_addr_o),
        .pmem_word_i(pmem_word_i), .pread_req_i(pread_req_i), .pread_addr_i(pread_addr_i),
        .pread_addr_o(pread_addr_o), .pread_valid_o(pread_valid_o),
        .pread_word_o(pread_word_o), .dreq_i(dreq_i), .dresp_o(dresp_o),
        .status_o(status_o), .ptr_o(ptr_o), .sfr_we_o(sfr_we_o), .sfr_addr_o(sfr_addr_o),
        .sfr_wdata_o(sfr_wdata_o), .sfr_rdata_i(sfr_rdata_i));
    task print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bits: advance, jump, interrupt, program read; held until the next call
    task cyc(input logic [3:0] f, input logic [12:0] ja, input logic [12:0] ra);
        {fetch_adv_i, jump_i, int_take_i, pread_req_i} = f;
        jump_addr_i = ja;
        pread_addr_i = ra;
        @(negedge ref_clk_i);
    endtask
    task dop(input logic w, input logic ind, input logic [6:0] x, input logic [7:0] v);
        dreq_i = '{1'b1, w, ind, x, v};
        @(negedge ref_clk_i);
        rsp = dresp_o;
        sw = sfr_we_o;
        sa = sfr_addr_o;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h2f7e));
        repeat (12) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        chk(pc_o, 16'h0000);
        cyc(4'h4, 13'h1ffe, 13'h0000);
        chk(pmem_addr_o, 16'h0ffe);
        for (int i = 0; i < 3; i++) begin
            a = pc_o;
            cyc(4'h8, 13'h0000, 13'h0000);
            chk(fetch_o.valid, 16'h0001);
            chk(fetch_o.addr, a);
            chk(fetch_o.word, pw(a & WM));
            a = a + 13'h0001;
            chk(pc_o, a);
            chk(pmem_addr_o, a & WM);
        end
        // Interrupt outranks jump and advance in the same cycle
        cyc(4'he, 13'h0123, 13'h0000);
        chk(pc_o, 16'h0004);
        chk(pmem_addr_o, 16'h0004);
        for (int i = 0; i < 6; i++) begin
            a = 13'($urandom);
            cyc(4'h1, 13'h0000, a);
            cyc(4'h0, 13'h0000, a);
            chk(pread_valid_o, 16'h0001);
            chk(pread_addr_o, a & WM);
            chk(pread_word_o, pw(a & WM));
        end
        for (int b = 0; b < 4; b++) begin
            d = 8'($urandom);
            ad = 7'h20 + 7'($urandom_range(32'h004f));
            sf = 7'h05 + 7'($urandom_range(32'h001a));
            dop(1'b1, 1'b0, STATUS_ADDR, 8'(b << 5));
            chk(status_o[6:5], 16'(b));
            // Shared top block written in the previous bank reads back here
            if (b > 0) begin
                dop(1'b0, 1'b0, COMMON_BASE, 8'h00);
                chk(rsp.rdata, cv);
            end
            cv = d ^ 8'h5a;
            dop(1'b1, 1'b0, COMMON_BASE, cv);
            dop(1'b1, 1'b0, ad, d);
            chk(rsp.valid, 16'h0000);
            dop(1'b0, 1'b0, ad, 8'h00);
            chk(rsp.valid, 16'h0001);
            chk(rsp.faddr, {2'(b), ad});
            chk(rsp.rdata, d);
            chk(rsp.is_sfr, 16'h0000);
            dop(1'b0, 1'b0, STATUS_ADDR, 8'h00);
            chk(rsp.rdata[6:5], 16'(b));
            chk(rsp.is_sfr, 16'h0001);
            dop(1'b1, 1'b0, sf, d);
            chk(sw, 16'h0001);
            chk(sa, {2'(b), sf});
            chk(sfr_wdata_o, d);
            dop(1'b0, 1'b0, sf, 8'h00);
            chk(rsp.rdata, {b[0], sf} ^ 8'h3c);
            dop(1'b1, 1'b0, PTR_ADDR, {b[0], ad});
            chk(ptr_o, {b[0], ad});
            dop(1'b0, 1'b1, IND_ADDR, 8'h00);
            chk(rsp.faddr, {2'(b), ad});
            chk(rsp.rdata, d);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
